// file: hw/pafo_port.sv
// Purpose: Port B/D/E registers with alternate function pin overrides
// Assumes: Fuses are static levels; pin levels are asynchronous
// Notes: Bus answers every access with one wait state
`default_nettype none
module pafo_port
    import pafo_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [PAFO_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic clock_out_fuse,
    input wire logic reset_pin_disable_fuse,
    input wire logic clkdiv_in,
    input wire pafo_pins_t pin_in,
    output pafo_pins_t pin_out,
    output pafo_pins_t pin_oe,
    output pafo_pins_t pin_pullup,
    output logic spi_slave_active,
    output logic ext_reset_req,
    output logic ext_interrupt2_input
);

    // ==========================================================
    // Reset release and input synchronisers
    logic [1:0] rst_sync_q;
    logic rst_i_n;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_i_n = rst_sync_q[1];

    pafo_pins_t pin_s1_q, pin_s2_q;
    always_ff @(posedge sys_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    // ==========================================================
    // Register file
    logic [7:0] pb_out_q, pb_out_d, pb_dir_q, pb_dir_d;
    logic [7:0] pd_out_q, pd_out_d, pd_dir_q, pd_dir_d;
    logic [3:0] pe_out_q, pe_out_d, pe_dir_q, pe_dir_d;
    logic [3:0] ctrl_q, ctrl_d;
    logic ack_q, ack_d, wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic req;
    logic reset_pin_mode;
    logic [3:0] pe_in_view;

    function automatic logic [7:0] be_merge(input logic [7:0] old,
                                           input logic [7:0] wd,
                                           input logic be);
        be_merge = be ? wd : old;
    endfunction

    function automatic logic hit(input logic [PAFO_AW-1:0] a,
                                 input logic [5:0] ofs);
        hit = (a == ofs);
    endfunction

    assign req = (avs_read | avs_write) & ~ack_q;
    // Fuse unprogrammed, pin belongs to reset
    assign reset_pin_mode = ~reset_pin_disable_fuse;

    always_comb begin
        pe_in_view = pin_s2_q.pe;
        pe_in_view[PAFO_PE_ANALOG_REFERENCE_PIN] = 1'b0;
        if (reset_pin_mode) begin
            pe_in_view[PAFO_PE_RST] = 1'b0;
        end
    end

    always_comb begin
        pb_out_d = pb_out_q;
        pb_dir_d = pb_dir_q;
        pd_out_d = pd_out_q;
        pd_dir_d = pd_dir_q;
        pe_out_d = pe_out_q;
        pe_dir_d = pe_dir_q;
        ctrl_d = ctrl_q;
        ack_d = req;
        wait_d = ~req;
        rdata_d = rdata_q;
        // Write lands on the acknowledge edge only
        if (avs_write && req) begin
            if (hit(avs_address, PAFO_OFS_PB_OUT)) begin
                pb_out_d = be_merge(pb_out_q, avs_writedata[7:0], avs_byteenable[0]);
            end
            if (hit(avs_address, PAFO_OFS_PB_DIR)) begin
                pb_dir_d = be_merge(pb_dir_q, avs_writedata[7:0], avs_byteenable[0]);
            end
            if (hit(avs_address, PAFO_OFS_PD_OUT)) begin
                pd_out_d = be_merge(pd_out_q, avs_writedata[7:0], avs_byteenable[0]);
            end
            if (hit(avs_address, PAFO_OFS_PD_DIR)) begin
                pd_dir_d = be_merge(pd_dir_q, avs_writedata[7:0], avs_byteenable[0]);
            end
            if (hit(avs_address, PAFO_OFS_PE_OUT) && avs_byteenable[0]) begin
                pe_out_d = avs_writedata[3:0];
            end
            if (hit(avs_address, PAFO_OFS_PE_DIR) && avs_byteenable[0]) begin
                pe_dir_d = avs_writedata[3:0];
            end
            if (hit(avs_address, PAFO_OFS_CTRL) && avs_byteenable[0]) begin
                ctrl_d = avs_writedata[3:0];
            end
        end
        if (avs_read && req) begin
            case (avs_address)
                PAFO_OFS_PB_OUT: rdata_d = {24'h000000, pb_out_q};
                PAFO_OFS_PB_DIR: rdata_d = {24'h000000, pb_dir_q};
                PAFO_OFS_PB_IN: rdata_d = {24'h000000, pin_s2_q.pb};
                PAFO_OFS_PD_OUT: rdata_d = {24'h000000, pd_out_q};
                PAFO_OFS_PD_DIR: rdata_d = {24'h000000, pd_dir_q};
                PAFO_OFS_PE_OUT: rdata_d = {28'h0000000,
                    pe_out_q & {3'h7, ~reset_pin_mode}};
                PAFO_OFS_PE_DIR: rdata_d = {28'h0000000,
                    pe_dir_q & {3'h7, ~reset_pin_mode}};
                PAFO_OFS_PE_IN: rdata_d = {28'h0000000, pe_in_view};
                PAFO_OFS_CTRL: rdata_d = {28'h0000000, ctrl_q};
                default: rdata_d = PAFO_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            pb_out_q <= PAFO_RST_PB_OUT;
            pb_dir_q <= PAFO_RST_PB_DIR;
            pd_out_q <= PAFO_RST_PD_OUT;
            pd_dir_q <= PAFO_RST_PD_DIR;
            pe_out_q <= PAFO_RST_PE;
            pe_dir_q <= PAFO_RST_PE;
            ctrl_q <= PAFO_RST_CTRL;
            ack_q <= 1'b0;
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            pb_out_q <= pb_out_d;
            pb_dir_q <= pb_dir_d;
            pd_out_q <= pd_out_d;
            pd_dir_q <= pd_dir_d;
            pe_out_q <= pe_out_d;
            pe_dir_q <= pe_dir_d;
            ctrl_q <= ctrl_d;
            ack_q <= ack_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    always_comb begin
        // Own flop, so the master never sees a gate
        avs_waitrequest = wait_q;
        avs_readdata = rdata_q;
    end

    // ==========================================================
    // Pin override logic
    logic spi_slave, spi_master, xout_taken, xin_taken;
    pafo_pins_t out_d, oe_d, pu_d;
    pafo_pins_t out_q, oe_q, pu_q;
    logic ssa_q, ssa_d, rreq_q, rreq_d, eint_q, eint_d;

    assign spi_slave = ctrl_q[PAFO_CTRL_SPI_EN] & ~ctrl_q[PAFO_CTRL_SPI_MST];
    assign spi_master = ctrl_q[PAFO_CTRL_SPI_EN] & ctrl_q[PAFO_CTRL_SPI_MST];
    assign xout_taken = ctrl_q[PAFO_CTRL_XTAL_OSC];
    assign xin_taken = ~ctrl_q[PAFO_CTRL_INT_RC];

    always_comb begin
        out_d.pb = pb_out_q;
        oe_d.pb = pb_dir_q;
        pu_d.pb = pb_out_q & ~pb_dir_q;
        out_d.pd = pd_out_q;
        oe_d.pd = pd_dir_q;
        pu_d.pd = pd_out_q & ~pd_dir_q;
        out_d.pe = pe_out_q;
        oe_d.pe = pe_dir_q;
        pu_d.pe = pe_out_q & ~pe_dir_q;
        if (spi_master) begin
            oe_d.pd[0] = pd_dir_q[0];
        end
        if (spi_slave) begin
            oe_d.pd[0] = 1'b0;
            pu_d.pd[0] = pd_out_q[0];
        end
        if (xout_taken) begin
            oe_d.pe[PAFO_PE_XOUT] = 1'b0;
            pu_d.pe[PAFO_PE_XOUT] = 1'b0;
        end
        if (xin_taken) begin
            oe_d.pe[PAFO_PE_XIN] = 1'b0;
            pu_d.pe[PAFO_PE_XIN] = 1'b0;
        end
        // Reset pin not usable as I/O
        if (reset_pin_mode) begin
            oe_d.pe[PAFO_PE_RST] = 1'b0;
            out_d.pe[PAFO_PE_RST] = 1'b0;
            pu_d.pe[PAFO_PE_RST] = 1'b1;
        end
        pu_d.pe[PAFO_PE_ANALOG_REFERENCE_PIN] = 1'b0;
        // Divided clock overrides data and direction
        if (clock_out_fuse) begin
            out_d.pd[0] = clkdiv_in;
            oe_d.pd[0] = 1'b1;
            pu_d.pd[0] = 1'b0;
        end
        // Slave active only while select low
        ssa_d = spi_slave & ~pin_s2_q.pd[0];
        rreq_d = reset_pin_mode & ~pin_s2_q.pe[PAFO_PE_RST];
        // Interrupt input follows the pin in either fuse setting
        eint_d = pin_s2_q.pe[PAFO_PE_RST];
    end

    always_ff @(posedge sys_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            out_q <= '0;
            oe_q <= '0;
            pu_q <= '0;
            ssa_q <= 1'b0;
            rreq_q <= 1'b0;
            eint_q <= 1'b0;
        end else begin
            out_q <= out_d;
            oe_q <= oe_d;
            pu_q <= pu_d;
            ssa_q <= ssa_d;
            rreq_q <= rreq_d;
            eint_q <= eint_d;
        end
    end

    logic divided_clock_output_q;
    always_ff @(posedge sys_clk) begin
        divided_clock_output_q <= clkdiv_in;
    end

    always_comb begin
        pin_out = out_q;
        pin_oe = oe_q;
        pin_pullup = pu_q;
        if (clock_out_fuse) begin
            pin_out.pd[0] = divided_clock_output_q;
            pin_oe.pd[0] = 1'b1;
        end
        spi_slave_active = ssa_q;
        ext_reset_req = rreq_q;
        ext_interrupt2_input = eint_q;
    end

    // ==========================================================
    // Checks
    sequence s_req_pending;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    property p_bus_ack;
        @(posedge sys_clk) disable iff (!rst_i_n)
        s_req_pending |=> !avs_waitrequest;
    endproperty
    a_bus_ack: assert property (p_bus_ack) else $error("no bus answer");

    property p_slave_ss_in;
        @(posedge sys_clk) disable iff (!rst_i_n)
        (spi_slave && !clock_out_fuse) |=> !pin_oe.pd[0];
    endproperty
    a_slave_ss_in: assert property (p_slave_ss_in) else $error("ss driven");

    property p_slave_act;
        @(posedge sys_clk) disable iff (!rst_i_n)
        spi_slave_active |-> $past(spi_slave && !pin_s2_q.pd[0]);
    endproperty
    a_slave_act: assert property (p_slave_act) else $error("bad spi active");

    property p_master_dir;
        @(posedge sys_clk) disable iff (!rst_i_n)
        (spi_master && !clock_out_fuse) |=> pin_oe.pd[0] == $past(pd_dir_q[0]);
    endproperty
    a_master_dir: assert property (p_master_dir) else $error("ss dir overridden");

    property p_slave_pu;
        @(posedge sys_clk) disable iff (!rst_i_n)
        (spi_slave && !clock_out_fuse) |=> pin_pullup.pd[0] == $past(pd_out_q[0]);
    endproperty
    a_slave_pu: assert property (p_slave_pu) else $error("ss pull-up wrong");

    property p_divided_clock_output;
        @(posedge sys_clk) disable iff (!rst_i_n)
        clock_out_fuse |-> pin_oe.pd[0];
    endproperty
    a_divided_clock_output: assert property (p_divided_clock_output) else $error("clock out not driven");

    property p_rst_read;
        @(posedge sys_clk) disable iff (!rst_i_n)
        (avs_read && req && reset_pin_mode && avs_address == PAFO_OFS_PE_IN)
            |=> avs_readdata[PAFO_PE_RST] == 1'b0;
    endproperty
    a_rst_read: assert property (p_rst_read) else $error("reset pin read");

    property p_analog_reference_pin;
        @(posedge sys_clk) disable iff (!rst_i_n)
        (avs_read && req && avs_address == PAFO_OFS_PE_IN)
            |=> avs_readdata[PAFO_PE_ANALOG_REFERENCE_PIN] == 1'b0;
    endproperty
    a_analog_reference_pin: assert property (p_analog_reference_pin) else $error("reference pin read");

    property p_dflt;
        @(posedge sys_clk) disable iff (!rst_i_n)
        1'b1 |=> pin_oe.pb == $past(pb_dir_q) && pin_out.pb == $past(pb_out_q);
    endproperty
    a_dflt: assert property (p_dflt) else $error("port b drive wrong");

    property p_xin;
        @(posedge sys_clk) disable iff (!rst_i_n)
        xin_taken |=> !pin_oe.pe[PAFO_PE_XIN];
    endproperty
    a_xin: assert property (p_xin) else $error("crystal in driven");

    property p_xout;
        @(posedge sys_clk) disable iff (!rst_i_n)
        xout_taken |=> !pin_oe.pe[PAFO_PE_XOUT] && !pin_pullup.pe[PAFO_PE_XOUT];
    endproperty
    a_xout: assert property (p_xout) else $error("crystal out driven");

    property p_rst_pin;
        @(posedge sys_clk) disable iff (!rst_i_n)
        reset_pin_mode |=> !pin_oe.pe[PAFO_PE_RST] && !pin_out.pe[PAFO_PE_RST];
    endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("reset pin driven");

endmodule
`default_nettype wire

// file: hw/pafo_pkg.sv
// Purpose: Shared constants and carriers for the port override block
// Assumes: 32-bit Avalon-MM register slave, word-aligned registers
// Notes: Offsets are byte addresses
`default_nettype none
package pafo_pkg;
    localparam int unsigned PAFO_AW = 6;
    localparam logic [5:0] PAFO_OFS_PB_OUT = 6'h00;
    localparam logic [5:0] PAFO_OFS_PB_DIR = 6'h04;
    localparam logic [5:0] PAFO_OFS_PB_IN = 6'h08;
    localparam logic [5:0] PAFO_OFS_PD_OUT = 6'h0C;
    localparam logic [5:0] PAFO_OFS_PD_DIR = 6'h10;
    localparam logic [5:0] PAFO_OFS_PE_OUT = 6'h14;
    localparam logic [5:0] PAFO_OFS_PE_DIR = 6'h18;
    localparam logic [5:0] PAFO_OFS_PE_IN = 6'h1C;
    localparam logic [5:0] PAFO_OFS_CTRL = 6'h20;
    localparam logic [7:0] PAFO_RST_PB_OUT = 8'h00;
    localparam logic [7:0] PAFO_RST_PB_DIR = 8'h00;
    localparam logic [7:0] PAFO_RST_PD_OUT = 8'h00;
    localparam logic [7:0] PAFO_RST_PD_DIR = 8'h00;
    localparam logic [3:0] PAFO_RST_PE = 4'h0;
    localparam logic [3:0] PAFO_RST_CTRL = 4'h0;
    // Control register fields
    localparam int unsigned PAFO_CTRL_SPI_EN = 0;
    localparam int unsigned PAFO_CTRL_SPI_MST = 1;
    localparam int unsigned PAFO_CTRL_INT_RC = 2;
    localparam int unsigned PAFO_CTRL_XTAL_OSC = 3;
    // Port E bits
    localparam int unsigned PAFO_PE_RST = 0;
    localparam int unsigned PAFO_PE_XIN = 1;
    localparam int unsigned PAFO_PE_XOUT = 2;
    localparam int unsigned PAFO_PE_ANALOG_REFERENCE_PIN = 3;
    localparam logic [31:0] PAFO_UNMAPPED = 32'h00000000;

    typedef struct packed {
        logic [7:0] pb;
        logic [7:0] pd;
        logic [3:0] pe;
    } pafo_pins_t;
endpackage
`default_nettype wire

// file: test/pafo_pin_model.sv
// Purpose: Board side of the port pins, resolving each pin level
// Assumes: Port driver wins over board drive, then pull-up, then float
// Notes: A floating pin toggles every cycle so it never looks stable
`default_nettype none
module pafo_pin_model
    import pafo_pkg::*;
(
    input wire logic sys_clk,
    input wire pafo_pins_t pin_out,
    input wire pafo_pins_t pin_oe,
    input wire pafo_pins_t pin_pullup,
    input wire pafo_pins_t ext_val,
    input wire pafo_pins_t ext_en,
    output pafo_pins_t pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic float_q = 1'b0;
    logic [19:0] oe_v, out_v, pu_v, ev, ee, lvl;
    assign oe_v = pin_oe;
    assign out_v = pin_out;
    assign pu_v = pin_pullup;
    assign ev = ext_val;
    assign ee = ext_en;
    assign pin_in = pafo_pins_t'(lvl);
    always_ff @(posedge sys_clk) begin
        float_q <= ~float_q;
    end
    // ==========================================
    // Pin resolution
    // board holds select, no drive
    always_comb begin
        for (int i = 0; i < 20; i++) begin
            lvl[i] = oe_v[i] ? out_v[i] : ee[i] ? ev[i] : pu_v[i] ? 1'b1 : float_q;
        end
    end
endmodule
`default_nettype wire

// file: test/tb.sv
// Purpose: Self-checking bench for the port override block
// Assumes: Fuses change only across a reset
// Notes: Random port values come from an LFSR seeded with 30
`default_nettype none
module tb
    import pafo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [PAFO_AW-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, spi_slave_active, ext_reset_req, ext_interrupt2_input;
    logic clock_out_fuse = 1'b0;
    logic reset_pin_disable_fuse = 1'b0;
    logic clkdiv_in = 1'b0;
    pafo_pins_t pin_in, pin_out, pin_oe, pin_pullup;
    pafo_pins_t ext_val = '0;
    pafo_pins_t ext_en = '0;
    int err_count = 0;
    int total_checks = 0;
    logic [7:0] lq = 8'h1E;
    logic [7:0] o, d, e;
    pafo_port pafo_port_inst (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .clock_out_fuse(clock_out_fuse),
        .reset_pin_disable_fuse(reset_pin_disable_fuse), .clkdiv_in(clkdiv_in),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .spi_slave_active(spi_slave_active), .ext_reset_req(ext_reset_req),
        .ext_interrupt2_input(ext_interrupt2_input));
    pafo_pin_model pafo_pin_model_inst (.sys_clk(sys_clk), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup(pin_pullup), .ext_val(ext_val), .ext_en(ext_en),
        .pin_in(pin_in));
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    // Divided clock stand-in, half the system rate
    always @(posedge sys_clk) begin
        clkdiv_in <= ~clkdiv_in;
    end
    // ==========================================
    // Helpers
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] pin_lvl(input logic [7:0] oe, input logic [7:0] ov,
                                           input logic [7:0] xv);
        return (oe & ov) | (~oe & xv);
    endfunction
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        total_checks++;
        if (got !== ex) begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, ex, got);
        end
    endtask
    task automatic chkb(input string nm, input logic ex, input logic got);
        chk(nm, 32'(ex), 32'(got));
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] wd,
                       input logic [3:0] be);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {24'h000000, wd};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // A slave that never answers ends the run here
        if (n >= 40) begin
            chk("bus_answer", 32'h1, 32'h0);
            end_sim();
        end
    endtask
    task automatic wr8(input logic [5:0] a, input logic [7:0] wd);
        bus(1'b1, a, wd, 4'hF);
    endtask
    task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] ex,
                        input logic [31:0] m);
        bus(1'b0, a, 8'h00, 4'hF);
        chk(nm, ex & m, rd & m);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic end_sim();
        if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        end_sim();
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rchk("pb_out", PAFO_OFS_PB_OUT, 32'h0, 32'hFFFFFFFF);
        rchk("pb_dir", PAFO_OFS_PB_DIR, 32'h0, 32'hFFFFFFFF);
        rchk("pd_out", PAFO_OFS_PD_OUT, 32'h0, 32'hFFFFFFFF);
        wt(0);
        chk("pb_oe", 32'h0, 32'(pin_oe.pb));
        for (int k = 0; k < 6; k++) begin
            o = nxt(lq);
            d = nxt(o);
            e = nxt(d);
            lq = e;
            if (k == 0) d = 8'hFF;
            if (k == 1) d = 8'h00;
            wr8(PAFO_OFS_PB_OUT, o);
            wr8(PAFO_OFS_PB_DIR, d);
            wr8(PAFO_OFS_PD_OUT, e);
            ext_en.pb <= ~d;
            ext_val.pb <= e;
            rchk("pb_out", PAFO_OFS_PB_OUT, 32'(o), 32'hFFFFFFFF);
            rchk("pb_dir", PAFO_OFS_PB_DIR, 32'(d), 32'hFFFFFFFF);
            rchk("pd_out", PAFO_OFS_PD_OUT, 32'(e), 32'hFFFFFFFF);
            wt(4);
            chk("pb_oe", 32'(d), 32'(pin_oe.pb));
            chk("pb_drive", 32'(o & d), 32'(pin_out.pb & d));
            chk("pb_pullup", 32'(o & ~d), 32'(pin_pullup.pb));
            rchk("pb_in", PAFO_OFS_PB_IN, 32'(pin_lvl(d, o, e)), 32'hFFFFFFFF);
        end
        bus(1'b1, PAFO_OFS_PB_OUT, ~o, 4'h0);
        rchk("pb_out_be", PAFO_OFS_PB_OUT, 32'(o), 32'hFFFFFFFF);
        rchk("unmapped", 6'h3C, PAFO_UNMAPPED, 32'hFFFFFFFF);
        wr8(PAFO_OFS_PD_DIR, 8'h01);
        wr8(PAFO_OFS_PD_OUT, 8'h01);
        wr8(PAFO_OFS_CTRL, 8'h01);
        ext_en.pd[0] <= 1'b1;
        ext_val.pd[0] <= 1'b0;
        wt(4);
        chkb("ss_oe_slave", 1'b0, pin_oe.pd[0]);
        chkb("ss_pullup", 1'b1, pin_pullup.pd[0]);
        chkb("spi_act_low", 1'b1, spi_slave_active);
        @(posedge sys_clk);
        ext_val.pd[0] <= 1'b1;
        wt(4);
        chkb("spi_act_high", 1'b0, spi_slave_active);
        @(posedge sys_clk);
        ext_en.pd[0] <= 1'b0;
        wr8(PAFO_OFS_CTRL, 8'h03);
        wt(2);
        chkb("ss_oe_master", 1'b1, pin_oe.pd[0]);
        wr8(PAFO_OFS_CTRL, 8'h00);
        // analog reference pin driven as output, no pull-up
        wr8(PAFO_OFS_PE_DIR, 8'h0B);
        wr8(PAFO_OFS_PE_OUT, 8'h0B);
        rchk("pe_dir0", PAFO_OFS_PE_DIR, 32'h0, 32'h1);
        rchk("pe_out0", PAFO_OFS_PE_OUT, 32'h0, 32'h1);
        ext_en.pe[0] <= 1'b1;
        ext_val.pe[0] <= 1'b0;
        wt(4);
        rchk("pe_in", PAFO_OFS_PE_IN, 32'h0, 32'h9);
        chkb("pe0_oe", 1'b0, pin_oe.pe[0]);
        chkb("rst_req", 1'b1, ext_reset_req);
        chkb("ext_interrupt2_input_low", 1'b0, ext_interrupt2_input);
        chkb("xin_oe", 1'b0, pin_oe.pe[1]);
        chkb("analog_reference_pin_oe", 1'b1, pin_oe.pe[3]);
        @(posedge sys_clk);
        ext_val.pe[0] <= 1'b1;
        wr8(PAFO_OFS_PE_DIR, 8'h06);
        wr8(PAFO_OFS_CTRL, 8'h0C);
        wt(4);
        chkb("rst_idle", 1'b0, ext_reset_req);
        chkb("ext_interrupt2_input_high", 1'b1, ext_interrupt2_input);
        chkb("xin_rc", 1'b1, pin_oe.pe[1]);
        chkb("xout_osc", 1'b0, pin_oe.pe[2]);
        @(posedge sys_clk);
        clock_out_fuse <= 1'b1;
        reset_pin_disable_fuse <= 1'b1;
        rst_n <= 1'b0;
        // Divided clock passes one register, so it lags the source by a cycle
        for (int k = 0; k < 3; k++) begin
            @(negedge sys_clk);
            chkb("divided_clock_output_rst", ~clkdiv_in, pin_out.pd[0]);
            chkb("divided_clock_output_oe_rst", 1'b1, pin_oe.pd[0]);
        end
        @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        wr8(PAFO_OFS_PE_DIR, 8'h01);
        wr8(PAFO_OFS_PE_OUT, 8'h01);
        ext_val.pe[0] <= 1'b0;
        rchk("pe_dir_io", PAFO_OFS_PE_DIR, 32'h1, 32'h1);
        wt(4);
        chkb("divided_clock_output", ~clkdiv_in, pin_out.pd[0]);
        chkb("divided_clock_output_oe", 1'b1, pin_oe.pd[0]);
        chkb("pe0_io_oe", 1'b1, pin_oe.pe[0]);
        chkb("pe0_io_out", 1'b1, pin_out.pe[0]);
        chkb("rst_off", 1'b0, ext_reset_req);
        end_sim();
    end
endmodule
`default_nettype wire
